//--- hw/dsau_top.sv
// data-space access unit: address scaling, byte lanes, alignment trap,
// working-register byte ops, control-area decode and the control word
// assumes the core holds off a new access until the previous one is done
`default_nettype none

module dsau_top
    import dsau_pkg::*;
#(
    parameter int          MEM_AW     = 12,
    parameter logic [63:0] REGION_MAP = DSAU_REGION_MAP
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // data access from the core
    input  wire logic        acc_req,
    input  wire logic        acc_we,
    input  wire logic        acc_byte,
    input  wire logic [1:0]  acc_mode,
    input  wire logic [15:0] acc_field,
    input  wire logic [15:0] acc_ptr,
    input  wire logic [15:0] acc_wdata,
    output var  logic        acc_done,
    output var  logic [15:0] acc_rdata,
    output var  logic [15:0] acc_addr,
    output var  logic [15:0] acc_ptr_next,
    output var  logic        addr_trap,
    // working register byte operations
    input  wire logic        ext_req,
    input  wire logic [1:0]  ext_op,
    input  wire logic [15:0] ext_reg,
    input  wire logic [7:0]  ext_byte,
    output var  logic        ext_done,
    output var  logic [15:0] ext_result,
    // core status
    input  wire logic [3:0]  cpu_ipl,
    output var  logic        user_irq_enable,
    output var  logic        program_space_view_enable
);

    // word index must fit bits 15..1 of the effective address
    if (MEM_AW < 4 || MEM_AW > 15) begin : g_aw_check
        $error("dsau_top: MEM_AW must lie in 4..15");
    end

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WAIT,
        ACC_TRAP
    } dsau_acc_t;

    function automatic logic [15:0] dsau_step(input logic byte_op);
        return byte_op ? DSAU_STEP_BYTE : DSAU_STEP_WORD;
    endfunction

    function automatic logic [1:0] dsau_lanes(input logic byte_op, input logic a0);
        if (!byte_op) begin
            return 2'h3;
        end
        return a0 ? 2'h2 : 2'h1;
    endfunction

    // reset release through two flops
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else if (ce) begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // effective address calculation
    logic [15:0] ea_nxt;
    logic        mis_nxt;
    logic        ctrl_nxt;
    logic        mapped_nxt;
    logic [5:0]  region_idx;

    always_comb begin
        case (dsau_mode_t'(acc_mode))
            DSAU_MODE_DIR13: ea_nxt = {3'h0, acc_field[DSAU_NEAR_AW-1:0]};
            DSAU_MODE_DIR16: ea_nxt = acc_field;
            DSAU_MODE_IND:   ea_nxt = acc_ptr;
            default:         ea_nxt = acc_ptr;
        endcase
    end

    // only word accesses trap on bit0
    assign mis_nxt    = !acc_byte && ea_nxt[0];
    assign ctrl_nxt   = ea_nxt <= DSAU_CTRL_TOP;
    assign region_idx = ea_nxt[DSAU_REGION_SHIFT+5:DSAU_REGION_SHIFT];

    always_comb begin
        if (ctrl_nxt) begin
            mapped_nxt = REGION_MAP[region_idx];
        end else begin
            // compare at 16 bits so the largest memory still maps
            mapped_nxt = {1'b0, ea_nxt[15:1]} < 16'(2**MEM_AW);
        end
    end

    // access sequencer
    dsau_acc_t   acc_st_r;
    logic        byte_r;
    logic        a0_r;
    logic        mis_r;
    logic        mapped_r;
    logic        mem_re;
    logic [1:0]  mem_we;
    logic [15:0] mem_rdata;
    logic [15:0] fault_addr_r;
    logic        acc_take;

    assign acc_take = acc_st_r == ACC_IDLE && acc_req;
    assign mem_re   = acc_take && !acc_we && mapped_nxt;
    // misaligned write executes but leaves memory untouched
    assign mem_we   = (acc_take && acc_we && mapped_nxt && !mis_nxt)
                    ? dsau_lanes(acc_byte, ea_nxt[0]) : 2'h0;

    dsau_mem #(
        .AW      (MEM_AW)
    ) u_mem (
        .clk     (clk),
        .ce      (ce),
        .addr    (ea_nxt[MEM_AW:1]),
        .re      (mem_re),
        .we      (mem_we),
        .wdata   (acc_byte ? {acc_wdata[7:0], acc_wdata[7:0]} : acc_wdata),
        .rdata_r (mem_rdata)
    );

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            acc_st_r <= ACC_IDLE;
        end else if (ce) begin
            case (acc_st_r)
                ACC_IDLE: if (acc_req) begin
                    acc_st_r <= ACC_WAIT;
                end
                ACC_WAIT: acc_st_r <= mis_r ? ACC_TRAP : ACC_IDLE;
                ACC_TRAP: acc_st_r <= ACC_IDLE;
                default:  acc_st_r <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            byte_r       <= 1'b0;
            a0_r         <= 1'b0;
            mis_r        <= 1'b0;
            mapped_r     <= 1'b0;
            acc_addr     <= 16'h0000;
            acc_ptr_next <= 16'h0000;
        end else if (ce && acc_take) begin
            byte_r   <= acc_byte;
            a0_r     <= ea_nxt[0];
            mis_r    <= mis_nxt;
            mapped_r <= mapped_nxt;
            acc_addr <= ea_nxt;
            if (dsau_mode_t'(acc_mode) == DSAU_MODE_POSTINC) begin
                acc_ptr_next <= acc_ptr + dsau_step(acc_byte);
            end else begin
                acc_ptr_next <= acc_ptr;
            end
        end
    end

    // fault address kept for software inspection
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fault_addr_r <= 16'h0000;
        end else if (ce && acc_take && mis_nxt) begin
            fault_addr_r <= ea_nxt;
        end
    end

    // read data return, trap one cycle after completion
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            acc_done  <= 1'b0;
            acc_rdata <= 16'h0000;
            addr_trap <= 1'b0;
        end else if (ce) begin
            acc_done  <= acc_st_r == ACC_WAIT;
            addr_trap <= acc_st_r == ACC_TRAP;
            if (acc_st_r == ACC_WAIT) begin
                if (!mapped_r) begin
                    acc_rdata <= 16'h0000;
                end else if (byte_r) begin
                    acc_rdata <= {8'h00, a0_r ? mem_rdata[15:8]
                                              : mem_rdata[7:0]};
                end else begin
                    acc_rdata <= mem_rdata;
                end
            end
        end
    end

    // working register byte operations
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ext_done   <= 1'b0;
            ext_result <= 16'h0000;
        end else if (ce) begin
            ext_done <= ext_req;
            if (ext_req) begin
                case (dsau_op_t'(ext_op))
                    DSAU_OP_LOADB: ext_result <= {ext_reg[15:8], ext_byte};
                    DSAU_OP_SIGNX: ext_result <= {{8{ext_reg[7]}}, ext_reg[7:0]};
                    DSAU_OP_ZEROX: ext_result <= {8'h00, ext_reg[7:0]};
                    default:       ext_result <= ext_reg;
                endcase
            end
        end
    end

    // wishbone slave
    logic wb_hit;
    logic wb_wr;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_hit && wb_we_i;

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= wb_hit;
        end
    end

    // control word: priority flag and program space view
    logic hi_prio;
    logic hi_prio_d_r;
    logic flag_r;
    logic cw_wr;
    assign hi_prio = cpu_ipl > DSAU_IPL_LIMIT;
    assign cw_wr   = wb_wr && wb_adr_i == DSAU_CW_OFS && wb_sel_i[0];

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            hi_prio_d_r <= 1'b0;
        end else if (ce) begin
            hi_prio_d_r <= hi_prio;
        end
    end

    // a rise in priority beats a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flag_r <= DSAU_CW_HI_RST;
        end else if (ce) begin
            if (hi_prio && !hi_prio_d_r) begin
                flag_r <= 1'b1;
            end else if (!hi_prio || (cw_wr && !wb_dat_i[DSAU_CW_HI_BIT])) begin
                flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            user_irq_enable <= 1'b1;
        end else if (ce) begin
            user_irq_enable <= !flag_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            program_space_view_enable <= DSAU_CW_PSV_RST;
        end else if (ce && cw_wr) begin
            program_space_view_enable <= wb_dat_i[DSAU_CW_PSV_BIT];
        end
    end

    // read mux, unmapped offsets answer zero
    logic [31:0] wb_rd;
    always_comb begin
        wb_rd = 32'h0000_0000;
        case (wb_adr_i)
            DSAU_CW_OFS: begin
                wb_rd[DSAU_CW_HI_BIT]  = flag_r;
                wb_rd[DSAU_CW_PSV_BIT] = program_space_view_enable;
            end
            DSAU_FAULT_OFS:  wb_rd = {16'h0000, fault_addr_r};
            DSAU_MAP_LO_OFS: wb_rd = REGION_MAP[31:0];
            DSAU_MAP_HI_OFS: wb_rd = REGION_MAP[63:32];
            default:         wb_rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce && wb_hit) begin
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : wb_rd;
        end
    end

endmodule // dsau_top

`default_nettype wire

//--- common/dsau_pkg.sv
// constants shared by the data-space access unit, its checker and its bench
// assumes a 16-bit core on one clock issuing one data access at a time
`default_nettype none

package dsau_pkg;

    // wishbone register map (byte addresses)
    localparam logic [7:0]  DSAU_CW_OFS        = 8'h00;
    localparam logic [7:0]  DSAU_FAULT_OFS     = 8'h04;
    localparam logic [7:0]  DSAU_MAP_LO_OFS    = 8'h08;
    localparam logic [7:0]  DSAU_MAP_HI_OFS    = 8'h0C;

    // control word fields and reset values
    localparam int          DSAU_CW_HI_BIT     = 3;
    localparam int          DSAU_CW_PSV_BIT    = 2;
    localparam logic        DSAU_CW_HI_RST     = 1'b0;
    localparam logic        DSAU_CW_PSV_RST    = 1'b0;
    localparam logic [3:0]  DSAU_IPL_LIMIT     = 4'h7;

    // data space layout
    localparam logic [15:0] DSAU_NEAR_TOP      = 16'h1FFF;
    localparam logic [15:0] DSAU_CTRL_TOP      = 16'h07FF;
    localparam int          DSAU_NEAR_AW       = 13;
    localparam int          DSAU_REGION_SHIFT  = 5;
    localparam int          DSAU_REGION_CNT    = 64;
    localparam logic [63:0] DSAU_REGION_MAP    = 64'h00FF_000F_00FF_FFFF;

    // pointer steps
    localparam logic [15:0] DSAU_STEP_BYTE     = 16'h0001;
    localparam logic [15:0] DSAU_STEP_WORD     = 16'h0002;

    typedef enum logic [1:0] {
        DSAU_MODE_DIR13,
        DSAU_MODE_DIR16,
        DSAU_MODE_IND,
        DSAU_MODE_POSTINC
    } dsau_mode_t;

    typedef enum logic [1:0] {
        DSAU_OP_LOADB,
        DSAU_OP_SIGNX,
        DSAU_OP_ZEROX,
        DSAU_OP_PASS
    } dsau_op_t;

endpackage : dsau_pkg

`default_nettype wire

//--- hw/dsau_mem.sv
// byte-laned word memory backing the data space
// assumes writes and reads are issued by the access unit on one clock
`default_nettype none

module dsau_mem #(
    parameter int AW = 12
) (
    // clock
    input  wire logic          clk,
    input  wire logic          ce,
    // access
    input  wire logic [AW-1:0] addr,
    input  wire logic          re,
    input  wire logic [1:0]    we,
    input  wire logic [15:0]   wdata,
    output var  logic [15:0]   rdata_r
);
    logic [7:0] lane_lo [2**AW];
    logic [7:0] lane_hi [2**AW];

    // two byte-wide arrays, one decode, separate write lines
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we[0]) begin
                lane_lo[addr] <= wdata[7:0];
            end
            if (we[1]) begin
                lane_hi[addr] <= wdata[15:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && re) begin
            rdata_r <= {lane_hi[addr], lane_lo[addr]};
        end
    end
endmodule // dsau_mem

`default_nettype wire

//--- test/dsau_checker.sv
// port assertions for the data-space access unit
// assumes ce is held high and the core holds fields until done
`default_nettype none

module dsau_checker
    import dsau_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    // core access
    input wire logic        acc_req,
    input wire logic        acc_byte,
    input wire logic        acc_done,
    input wire logic [15:0] acc_addr,
    input wire logic        addr_trap,
    // status
    input wire logic [3:0]  cpu_ipl,
    input wire logic        user_irq_enable,
    input wire logic        program_space_view_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence acc_start_s;
        acc_req ##2 acc_done;
    endsequence
    sequence word_odd_s;
        acc_done && !acc_byte && acc_addr[0];
    endsequence

    ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    done_latency_a: assert property (acc_req |-> acc_start_s)
        else $error("access not done in two cycles");
    trap_odd_a: assert property (word_odd_s |=> addr_trap)
        else $error("odd word access without trap");
    trap_none_a: assert property (acc_done && (acc_byte || !acc_addr[0]) |=> !addr_trap)
        else $error("trap on aligned or byte access");
    trap_after_a: assert property (addr_trap |-> $past(acc_done))
        else $error("trap not right after done");
    prio_block_a: assert property ($rose(cpu_ipl > DSAU_IPL_LIMIT) |-> ##[1:3] !user_irq_enable)
        else $error("user irq not blocked");
    prio_clear_a: assert property ((cpu_ipl <= DSAU_IPL_LIMIT) [*4] |-> user_irq_enable)
        else $error("user irq blocked at low priority");
    view_write_a: assert property ($changed(program_space_view_enable) |-> wb_ack_o && wb_we_i)
        else $error("view enable moved without write");
endmodule // dsau_checker

`default_nettype wire

//--- test/dsau_core_model.sv
// core-side model issuing one data access at a time
// assumes the unit answers within a few cycles
`default_nettype none

module dsau_core_model (
    // clock
    input wire logic        clk,
    // access
    output var logic        acc_req,
    output var logic        acc_we,
    output var logic        acc_byte,
    output var logic [1:0]  acc_mode,
    output var logic [15:0] acc_field,
    output var logic [15:0] acc_ptr,
    output var logic [15:0] acc_wdata,
    input wire logic        acc_done,
    input wire logic [15:0] acc_rdata,
    input wire logic        addr_trap
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {acc_req, acc_we, acc_byte, acc_mode} = '0;
        {acc_field, acc_ptr, acc_wdata} = '0;
    end

    task automatic access(input logic we, input logic byt, input logic [1:0] mode,
                          input logic [15:0] adr, input logic [15:0] wd,
                          output logic [15:0] rd, output logic trap, output bit ok);
        int n;
        @(posedge clk);
        {acc_req, acc_we, acc_byte, acc_mode} <= {1'b1, we, byt, mode};
        {acc_field, acc_ptr, acc_wdata} <= {adr, adr, wd};
        @(posedge clk);
        acc_req <= 1'b0;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = acc_done;
        end
        rd = acc_rdata;
        // released fields must not look valid
        {acc_field, acc_ptr, acc_wdata} <= ~{adr, adr, wd};
        @(posedge clk);
        trap = addr_trap;
    endtask
endmodule // dsau_core_model

`default_nettype wire

//--- test/dsau_top_tb.sv
// self-checking bench for the data-space access unit
// assumes checker and core model are compiled first
`default_nettype none

module dsau_top_tb
    import dsau_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, wb_ack_o, ext_req = 1'b0, ext_done;
    logic        acc_req, acc_we, acc_byte, acc_done, addr_trap;
    logic        user_irq_enable, program_space_view_enable;
    logic [1:0]  acc_mode, ext_op = '0;
    logic [3:0]  wb_sel_i = '0, cpu_ipl = '0;
    logic [7:0]  wb_adr_i = '0, ext_byte = 8'hAB;
    logic [15:0] acc_field, acc_ptr, acc_wdata, acc_rdata, acc_addr, acc_ptr_next;
    logic [15:0] ext_reg = '0, ext_result, r;
    logic [31:0] wb_dat_i = '0, wb_dat_o, d;
    logic        t;
    int          failures = 0, n_checks = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    dsau_top uut (.clk, .rstn, .ce(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .acc_req, .acc_we, .acc_byte,
        .acc_mode, .acc_field, .acc_ptr, .acc_wdata, .acc_done, .acc_rdata, .acc_addr,
        .acc_ptr_next, .addr_trap, .ext_req, .ext_op, .ext_reg, .ext_byte, .ext_done,
        .ext_result, .cpu_ipl, .user_irq_enable, .program_space_view_enable);
    dsau_core_model core (.clk, .acc_req, .acc_we, .acc_byte, .acc_mode, .acc_field,
        .acc_ptr, .acc_wdata, .acc_done, .acc_rdata, .addr_trap);

    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string s);
        check({31'h0, got}, {31'h0, exp}, s);
    endtask

    task automatic hang(input string s);
        check(32'h0, 32'h1, s);
        results();
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
        {wb_adr_i, wb_dat_i} <= {adr, wd};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 20) hang("wishbone timeout");
        d = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        wb_dat_i <= ~wd;
    endtask

    task automatic acc(input logic we, input logic byt, input logic [1:0] mode,
                       input logic [15:0] adr, input logic [15:0] wd);
        bit ok;
        core.access(we, byt, mode, adr, wd, r, t, ok);
        if (!ok) hang("access timeout");
    endtask

    task automatic t_ctrl();
        wb(1'b0, DSAU_CW_OFS, 32'h0);
        check(d, 32'h0, "control reset");
        wb(1'b1, DSAU_CW_OFS, 32'hFFFF_FFFF);
        wb(1'b0, DSAU_CW_OFS, 32'h0);
        check(d, 32'h0000_0004, "control ones");
        check_bit(program_space_view_enable, 1'b1, "view on");
        wb(1'b1, DSAU_CW_OFS, 32'h0);
        check_bit(program_space_view_enable, 1'b0, "view off");
        wb(1'b0, 8'h40, 32'h0);
        check(d, 32'h0, "unmapped");
        $display("control word done");
    endtask

    task automatic t_prio();
        cpu_ipl <= 4'h7;
        repeat (4) @(posedge clk);
        wb(1'b0, DSAU_CW_OFS, 32'h0);
        check(d, 32'h0, "flag at seven");
        cpu_ipl <= 4'h8;
        repeat (4) @(posedge clk);
        wb(1'b0, DSAU_CW_OFS, 32'h0);
        check(d, 32'h0000_0008, "flag above seven");
        check_bit(user_irq_enable, 1'b0, "irq blocked");
        wb(1'b1, DSAU_CW_OFS, 32'h0);
        wb(1'b0, DSAU_CW_OFS, 32'h0);
        check(d, 32'h0, "flag cleared");
        cpu_ipl <= 4'h3;
        repeat (4) @(posedge clk);
        check_bit(user_irq_enable, 1'b1, "irq allowed");
        $display("priority done");
    endtask

    task automatic t_data();
        acc(1'b1, 1'b0, DSAU_MODE_DIR16, 16'h0900, 16'h1234);
        acc(1'b1, 1'b1, DSAU_MODE_IND, 16'h0901, 16'h55AB);
        check_bit(t, 1'b0, "odd byte trap");
        acc(1'b0, 1'b0, DSAU_MODE_DIR16, 16'h0900, 16'h0);
        check(r, 16'hAB34, "lane write");
        acc(1'b0, 1'b1, DSAU_MODE_IND, 16'h0901, 16'h0);
        check(r, 16'h00AB, "odd byte read");
        acc(1'b0, 1'b1, DSAU_MODE_IND, 16'h0900, 16'h0);
        check(r, 16'h0034, "even byte read");
        acc(1'b0, 1'b0, DSAU_MODE_DIR13, 16'hE900, 16'h0);
        check(acc_addr, 16'h0900, "near field");
        for (int k = 0; k < 2; k++) begin
            acc(1'b0, k[0], DSAU_MODE_POSTINC, 16'h0A02, 16'h0);
            check(acc_ptr_next, k ? 16'h0A03 : 16'h0A04, "pointer step");
        end
        $display("data path done");
    endtask

    task automatic t_trap();
        acc(1'b1, 1'b0, DSAU_MODE_DIR16, 16'h0A02, 16'h1111);
        acc(1'b1, 1'b0, DSAU_MODE_DIR16, 16'h0A03, 16'h5555);
        check_bit(t, 1'b1, "odd write trap");
        acc(1'b0, 1'b0, DSAU_MODE_DIR16, 16'h0A02, 16'h0);
        check(r, 16'h1111, "write suppressed");
        check_bit(t, 1'b0, "even read trap");
        acc(1'b0, 1'b0, DSAU_MODE_IND, 16'h0A03, 16'h0);
        check_bit(t, 1'b1, "odd read trap");
        check(r, 16'h1111, "odd read data");
        acc(1'b1, 1'b0, DSAU_MODE_DIR16, 16'h02FE, 16'hBEEF);
        acc(1'b1, 1'b0, DSAU_MODE_DIR16, 16'h0300, 16'hBEEF);
        acc(1'b0, 1'b0, DSAU_MODE_DIR16, 16'h02FE, 16'h0);
        check(r, 16'hBEEF, "used region");
        acc(1'b0, 1'b0, DSAU_MODE_DIR16, 16'h0300, 16'h0);
        check(r, 16'h0, "empty region");
        wb(1'b0, DSAU_FAULT_OFS, 32'h0);
        check(d, 32'h0000_0A03, "fault address");
        wb(1'b0, DSAU_MAP_LO_OFS, 32'h0);
        check(d, DSAU_REGION_MAP[31:0], "region map");
        $display("trap and regions done");
    endtask

    task automatic t_ext();
        logic [15:0] rv [5] = '{16'h1234, 16'h0080, 16'h127F, 16'hFF80, 16'hC3A5};
        logic [15:0] ev [5] = '{16'h12AB, 16'hFF80, 16'h007F, 16'h0080, 16'hC3A5};
        dsau_op_t    ov [5] = '{DSAU_OP_LOADB, DSAU_OP_SIGNX, DSAU_OP_SIGNX,
                                DSAU_OP_ZEROX, DSAU_OP_PASS};
        int n;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            {ext_req, ext_op, ext_reg} <= {1'b1, ov[i], rv[i]};
            @(posedge clk);
            ext_req <= 1'b0;
            for (n = 0; n < 8 && ext_done !== 1'b1; n++) begin
                @(posedge clk);
            end
            if (n == 8) hang("byte op timeout");
            check(ext_result, ev[i], "byte op");
            ext_reg <= ~rv[i];
        end
        $display("byte ops done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_ctrl();
        t_prio();
        t_data();
        t_trap();
        t_ext();
        results();
    end
endmodule // dsau_top_tb

bind dsau_top dsau_checker chk (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .acc_req, .acc_byte, .acc_done, .acc_addr, .addr_trap, .cpu_ipl, .user_irq_enable,
    .program_space_view_enable);

`default_nettype wire
